// ==== spp_loop_model.sv ====
// Control loop model that consumes the running setpoint.
`timescale 1ns/100ps
`default_nettype none
module spp_loop_model (
    // Clock and reset
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    // Setpoint in, loop target out
    input  wire logic signed [spp_pkg::SP_W-1:0]   setpoint_in,
    output logic signed      [spp_pkg::SP_W-1:0]   loop_target
);
    import spp_pkg::*;
    // The loop samples once a clock, so it only ever sees settled values.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_target <= '0;
        end else begin
            loop_target <= setpoint_in;
        end
    end
endmodule : spp_loop_model
`default_nettype wire

// ==== spp_mem.sv ====
// Target and duration store for the ten profile segments.
`timescale 1ns/100ps
`default_nettype none
module spp_mem
    import spp_pkg::*;
(
    // Clock, reset and enable
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      ce,
    // Write port
    input  wire logic                      we_tgt,
    input  wire logic                      we_dur,
    input  wire logic [spp_pkg::IDX_W-1:0] waddr,
    input  wire logic [spp_pkg::SP_W-1:0]  wdata_tgt,
    input  wire logic [spp_pkg::DUR_W-1:0] wdata_dur,
    // Bus read port
    input  wire logic [spp_pkg::IDX_W-1:0] raddr_a,
    output logic      [spp_pkg::SP_W-1:0]  rtgt_a,
    output logic      [spp_pkg::DUR_W-1:0] rdur_a,
    // Sequencer read port
    input  wire logic [spp_pkg::IDX_W-1:0] raddr_b,
    output logic      [spp_pkg::SP_W-1:0]  rtgt_b,
    output logic      [spp_pkg::DUR_W-1:0] rdur_b
);
    logic [SP_W-1:0]  tgt_q [NUM_SEG];
    logic [DUR_W-1:0] dur_q [NUM_SEG];

    // ==========================================================================
    // Storage, one generate slice per entry so each resets to its default.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SEG; gi++) begin : g_ent
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tgt_q[gi] <= SP_DEFAULT;
                    dur_q[gi] <= DUR_ZERO;
                end else if (ce && waddr == IDX_W'(gi)) begin
                    if (we_tgt) begin
                        tgt_q[gi] <= wdata_tgt;
                    end
                    if (we_dur) begin
                        dur_q[gi] <= wdata_dur;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================================
    // Registered reads; an index past the last entry reads as zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtgt_a <= '0;
            rdur_a <= '0;
            rtgt_b <= '0;
            rdur_b <= '0;
        end else if (ce) begin
            rtgt_a <= (raddr_a < IDX_COUNT) ? tgt_q[raddr_a] : '0;
            rdur_a <= (raddr_a < IDX_COUNT) ? dur_q[raddr_a] : '0;
            rtgt_b <= (raddr_b < IDX_COUNT) ? tgt_q[raddr_b] : '0;
            rdur_b <= (raddr_b < IDX_COUNT) ? dur_q[raddr_b] : '0;
        end
    end

endmodule : spp_mem
`default_nettype wire

// ==== spp_pkg.sv ====
// Shared constants and types for the setpoint profile sequencer.
package spp_pkg;

    // ==========================================================================
    // Sizes
    localparam int unsigned NUM_SEG = 10;
    localparam int unsigned IDX_W   = 4;
    localparam int unsigned SP_W    = 16;
    localparam int unsigned DUR_W   = 14;
    localparam int unsigned CNT_W   = 8;
    localparam int unsigned TICK_W  = 36;
    localparam int unsigned ADDR_W  = 12;

    // ==========================================================================
    // Value ranges and reset values
    localparam logic [IDX_W-1:0]        IDX_FIRST        = 4'h0;
    localparam logic [IDX_W-1:0]        IDX_LAST         = 4'h9;
    localparam logic [IDX_W-1:0]        IDX_COUNT        = 4'ha;
    localparam logic signed [SP_W-1:0]  SP_MIN           = 16'shfc19;
    localparam logic signed [SP_W-1:0]  SP_MAX           = 16'sh270f;
    localparam logic signed [SP_W-1:0]  SP_DEFAULT       = 16'sh1388;
    localparam logic signed [SP_W-1:0]  LOCAL_SP_DEFAULT = 16'sh0000;
    localparam logic [DUR_W-1:0]        DUR_ZERO         = 14'h0000;
    localparam logic [DUR_W-1:0]        DUR_MAX          = 14'h270f;
    localparam logic [CNT_W-1:0]        CNT_ZERO         = 8'h00;
    localparam logic [CNT_W-1:0]        CNT_MIN          = 8'h01;
    localparam logic [CNT_W-1:0]        CNT_MAX          = 8'hfa;
    localparam logic [CNT_W-1:0]        CNT_DEFAULT      = 8'h01;

    // ==========================================================================
    // Time base: one tick per minute
    localparam longint unsigned MINUTE_S    = 60;
    localparam longint unsigned CLK_HZ      = 100_000_000;
    localparam logic [TICK_W-1:0] TICK_CYCLES = TICK_W'(MINUTE_S * CLK_HZ);

    // ==========================================================================
    // Register byte offsets and field positions
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_COUNT    = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_LOCAL    = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_SETP     = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_TGT_BASE = 12'h040;
    localparam logic [ADDR_W-1:0] OFF_DUR_BASE = 12'h080;
    localparam int unsigned       STAT_ACT_BIT  = 0;
    localparam int unsigned       STAT_SUSP_BIT = 1;
    localparam int unsigned       STAT_IDX_LSB  = 4;

    // ==========================================================================
    // Program state setting and sequencer states
    typedef enum logic [1:0] {
        SPP_MODE_OFF  = 2'h0,
        SPP_MODE_RUN  = 2'h1,
        SPP_MODE_SUSP = 2'h2
    } spp_mode_e;

    typedef enum logic [5:0] {
        SPP_ST_OFF  = 6'h01,
        SPP_ST_LOAD = 6'h02,
        SPP_ST_WAIT = 6'h04,
        SPP_ST_RAMP = 6'h08,
        SPP_ST_SUSP = 6'h10,
        SPP_ST_WRAP = 6'h20
    } spp_state_e;

endpackage : spp_pkg

// ==== spp_seq.sv ====
// Setpoint profile sequencer with its APB register slave.
//
// Overview of operation
// - Profile holds up to ten targets, indexed one to ten, and may repeat.
// - Segment one ramps from local setpoint; segment n from target n-1 to n.
// - On finishing, the local setpoint takes the last profile value.
// - Program state is run, off or suspended; suspended freezes the output.
// - Selecting run while suspended resumes from the frozen point.
// - A repeat tally of 250 runs the profile forever.
// - While running, the tally ignores writes and shows cycles remaining.
// - The tally accepts 1 to 250 and resets to 1.
// - Each segment duration is 0 to 9999 minutes, default zero.
// - A zero duration ends the cycle at that index.
// - Equal adjacent targets give a hold lasting the second duration.
// - The evolving profile setpoint is shown on the lower display.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module spp_seq
    import spp_pkg::*;
#(
    parameter logic [spp_pkg::TICK_W-1:0] TICK_CYCLES = spp_pkg::TICK_CYCLES
) (
    // Clock, reset and enable
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              ce,
    // APB slave
    input  wire logic [spp_pkg::ADDR_W-1:0]        paddr,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [31:0]                       pwdata,
    output logic                                   pready,
    output logic      [31:0]                       prdata,
    output logic                                   pslverr,
    // Setpoint towards the control loop and the lower display
    output logic signed [spp_pkg::SP_W-1:0]        setpoint_out,
    output logic signed [spp_pkg::SP_W-1:0]        local_setpoint,
    output logic                                   profile_active
);
    import spp_pkg::*;

    spp_state_e               state_q;
    spp_mode_e                mode_q;
    logic [CNT_W-1:0]         prog_cnt_q, remain_q;
    logic signed [SP_W-1:0]   local_sp_q, out_sp_q, start_q, end_q;
    logic [DUR_W-1:0]         dur_q, elapsed_q;
    logic [IDX_W-1:0]         idx_q;
    logic [TICK_W-1:0]        tick_cnt_q;
    logic                     ack_q;
    logic [31:0]              prdata_q;
    logic [SP_W-1:0]          rtgt_a, rtgt_b;
    logic [DUR_W-1:0]         rdur_a, rdur_b;

    // ==========================================================================
    // APB decode. A transfer takes two access cycles while ce is high: the first loads the
    // read data flop, the second raises pready, so prdata is always a flop.
    logic             acc, wr_fire, rd_load, word_ok;
    logic             hit_ctrl, hit_cnt, hit_local, hit_stat, hit_setp, hit_tgt, hit_dur;
    logic             mapped, wr_ok, active;
    logic [IDX_W-1:0] bus_idx;
    logic signed [SP_W-1:0] wsp;

    assign acc       = psel && penable;
    assign wr_fire   = acc && pwrite && ack_q;
    assign rd_load   = acc && !ack_q;
    assign word_ok   = paddr[1:0] == 2'h0;
    assign bus_idx   = paddr[5:2];
    assign wsp       = $signed(pwdata[SP_W-1:0]);
    assign active    = state_q != SPP_ST_OFF;
    assign hit_ctrl  = paddr == OFF_CTRL;
    assign hit_cnt   = paddr == OFF_COUNT;
    assign hit_local = paddr == OFF_LOCAL;
    assign hit_stat  = paddr == OFF_STATUS;
    assign hit_setp  = paddr == OFF_SETP;
    assign hit_tgt   = word_ok && paddr[11:6] == OFF_TGT_BASE[11:6] && bus_idx < IDX_COUNT;
    assign hit_dur   = word_ok && paddr[11:6] == OFF_DUR_BASE[11:6] && bus_idx < IDX_COUNT;
    assign mapped    = hit_ctrl || hit_cnt || hit_local || hit_stat || hit_setp
                       || hit_tgt || hit_dur;

    // Writes carrying a value outside the documented range are dropped.
    always_comb begin
        wr_ok = 1'b0;
        if (hit_ctrl) begin
            wr_ok = pwdata[1:0] != 2'h3;
        end else if (hit_cnt) begin
            wr_ok = !active && pwdata <= 32'(CNT_MAX) && pwdata >= 32'(CNT_MIN);
        end else if (hit_local || hit_tgt) begin
            wr_ok = wsp >= SP_MIN && wsp <= SP_MAX;
        end else if (hit_dur) begin
            wr_ok = pwdata <= 32'(DUR_MAX);
        end
    end

    // Holding pready low while ce is low keeps the master waiting, not lost.
    assign pready  = ack_q && ce;
    assign pslverr = pready && (!mapped || (pwrite && !wr_ok));
    assign prdata  = prdata_q;

    // Access handshake flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_q <= 1'b0;
        end else if (ce) begin
            ack_q <= rd_load;
        end
    end

    // Read data mux into its flop on the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (ce && rd_load) begin
            prdata_q <= '0;
            if (hit_ctrl) begin
                prdata_q[1:0] <= mode_q;
            end else if (hit_cnt) begin
                prdata_q[CNT_W-1:0] <= active ? remain_q : prog_cnt_q;
            end else if (hit_local) begin
                prdata_q[SP_W-1:0] <= local_sp_q;
            end else if (hit_stat) begin
                prdata_q[STAT_ACT_BIT]                  <= active;
                prdata_q[STAT_SUSP_BIT]                 <= state_q == SPP_ST_SUSP;
                prdata_q[STAT_IDX_LSB +: IDX_W]         <= idx_q;
            end else if (hit_setp) begin
                prdata_q[SP_W-1:0] <= out_sp_q;
            end else if (hit_tgt) begin
                prdata_q[SP_W-1:0] <= rtgt_a;
            end else if (hit_dur) begin
                prdata_q[DUR_W-1:0] <= rdur_a;
            end
        end
    end

    // ==========================================================================
    // Segment store. Targets may be rewritten while running; the operator is
    // expected to finish programming before run, so no lockout is applied.
    spp_mem u_mem (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .we_tgt    (wr_fire && hit_tgt && wr_ok),
        .we_dur    (wr_fire && hit_dur && wr_ok),
        .waddr     (bus_idx),
        .wdata_tgt (pwdata[SP_W-1:0]),
        .wdata_dur (pwdata[DUR_W-1:0]),
        .raddr_a   (bus_idx),
        .rtgt_a    (rtgt_a),
        .rdur_a    (rdur_a),
        .raddr_b   (idx_q),
        .rtgt_b    (rtgt_b),
        .rdur_b    (rdur_b)
    );

    // ==========================================================================
    // Sequencer events.
    logic                   tick, seg_done, finish, continuous;
    logic [DUR_W-1:0]       el_nx;
    logic signed [SP_W:0]   diff;
    logic signed [31:0]     prod, quot;
    logic signed [SP_W-1:0] interp;

    assign tick       = state_q == SPP_ST_RAMP && tick_cnt_q == TICK_CYCLES - 1'b1;
    assign el_nx      = elapsed_q + 1'b1;
    assign seg_done   = tick && el_nx == dur_q;
    assign continuous = remain_q == CNT_MAX;
    assign finish     = (state_q == SPP_ST_WRAP && !continuous && remain_q <= CNT_MIN)
                        || (state_q == SPP_ST_WAIT && rdur_b == DUR_ZERO
                            && idx_q == IDX_FIRST);

    // Linear interpolation on the elapsed fraction; equal ends give a hold.
    assign diff   = (SP_W+1)'(end_q) - (SP_W+1)'(start_q);
    assign prod   = 32'(diff) * $signed({18'h00000, el_nx});
    assign quot   = prod / $signed({18'h00000, dur_q});
    assign interp = start_q + quot[SP_W-1:0];

    // Minute time base, kept through suspension so the fraction survives.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= '0;
        end else if (ce) begin
            if (tick || (state_q != SPP_ST_RAMP && state_q != SPP_ST_SUSP)) begin
                tick_cnt_q <= '0;
            end else if (state_q == SPP_ST_RAMP) begin
                tick_cnt_q <= tick_cnt_q + 1'b1;
            end
        end
    end

    // ==========================================================================
    // Program state setting; the sequencer returns it to off when done.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= SPP_MODE_OFF;
        end else if (ce) begin
            if (wr_fire && hit_ctrl && wr_ok) begin
                mode_q <= spp_mode_e'(pwdata[1:0]);
            end else if (finish) begin
                mode_q <= SPP_MODE_OFF;
            end
        end
    end

    // Programmed tally, locked while a profile runs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_cnt_q <= CNT_DEFAULT;
        end else if (ce && wr_fire && hit_cnt && wr_ok) begin
            prog_cnt_q <= pwdata[CNT_W-1:0];
        end
    end

    // Local setpoint: software value, replaced by the last profile value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            local_sp_q <= LOCAL_SP_DEFAULT;
        end else if (ce) begin
            if (finish) begin
                local_sp_q <= out_sp_q;
            end else if (wr_fire && hit_local && wr_ok) begin
                local_sp_q <= wsp;
            end
        end
    end

    // ==========================================================================
    // Sequencer state machine. Off from the operator aborts at once and
    // leaves the local setpoint alone.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= SPP_ST_OFF;
            idx_q     <= IDX_FIRST;
            remain_q  <= CNT_ZERO;
            out_sp_q  <= LOCAL_SP_DEFAULT;
            start_q   <= LOCAL_SP_DEFAULT;
            end_q     <= LOCAL_SP_DEFAULT;
            dur_q     <= DUR_ZERO;
            elapsed_q <= DUR_ZERO;
        end else if (ce) begin
            if (state_q != SPP_ST_OFF && mode_q == SPP_MODE_OFF) begin
                state_q <= SPP_ST_OFF;
            end else begin
                case (state_q)
                    SPP_ST_OFF: begin
                        out_sp_q <= local_sp_q;
                        if (mode_q == SPP_MODE_RUN) begin
                            idx_q    <= IDX_FIRST;
                            start_q  <= local_sp_q;
                            remain_q <= prog_cnt_q;
                            state_q  <= SPP_ST_LOAD;
                        end
                    end
                    SPP_ST_LOAD: begin
                        state_q <= SPP_ST_WAIT;
                    end
                    SPP_ST_WAIT: begin
                        if (rdur_b == DUR_ZERO) begin
                            state_q <= (idx_q == IDX_FIRST) ? SPP_ST_OFF : SPP_ST_WRAP;
                        end else begin
                            end_q     <= $signed(rtgt_b);
                            dur_q     <= rdur_b;
                            elapsed_q <= DUR_ZERO;
                            state_q   <= SPP_ST_RAMP;
                        end
                    end
                    SPP_ST_RAMP: begin
                        if (mode_q == SPP_MODE_SUSP) begin
                            state_q <= SPP_ST_SUSP;
                        end else if (seg_done) begin
                            out_sp_q <= end_q;
                            start_q  <= end_q;
                            if (idx_q == IDX_LAST) begin
                                state_q <= SPP_ST_WRAP;
                            end else begin
                                idx_q   <= idx_q + 1'b1;
                                state_q <= SPP_ST_LOAD;
                            end
                        end else if (tick) begin
                            elapsed_q <= el_nx;
                            out_sp_q  <= interp;
                        end
                    end
                    SPP_ST_SUSP: begin
                        if (mode_q == SPP_MODE_RUN) begin
                            state_q <= SPP_ST_RAMP;
                        end
                    end
                    SPP_ST_WRAP: begin
                        if (finish) begin
                            remain_q <= CNT_ZERO;
                            state_q  <= SPP_ST_OFF;
                        end else begin
                            if (!continuous) begin
                                remain_q <= remain_q - 1'b1;
                            end
                            idx_q   <= IDX_FIRST;
                            start_q <= out_sp_q;
                            state_q <= SPP_ST_LOAD;
                        end
                    end
                    default: begin
                        state_q <= SPP_ST_OFF;
                    end
                endcase
            end
        end
    end

    assign setpoint_out   = out_sp_q;
    assign local_setpoint = local_sp_q;
    assign profile_active = active;

    // ==========================================================================
    // Checks.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_IDX_RANGE: assert property (idx_q <= IDX_LAST)
        else $error("Segment index past the tenth entry.");
    AST_FIRST_FROM_LOCAL: assert property (ce && state_q == SPP_ST_OFF
        && mode_q == SPP_MODE_RUN |=> start_q == $past(local_sp_q) && idx_q == IDX_FIRST)
        else $error("First segment does not start at the local setpoint.");
    AST_FINISH_LOAD: assert property (ce && finish |=> local_sp_q == $past(out_sp_q)
        && state_q == SPP_ST_OFF)
        else $error("Local setpoint not loaded at finish.");
    AST_SUSP_FREEZE: assert property (state_q == SPP_ST_SUSP ##1 state_q == SPP_ST_SUSP
        |-> $stable(out_sp_q))
        else $error("Output moved while suspended.");
    AST_RESUME: assert property (ce && state_q == SPP_ST_SUSP && mode_q == SPP_MODE_RUN
        |=> state_q == SPP_ST_RAMP && $stable(elapsed_q))
        else $error("Run did not resume from the frozen point.");
    AST_CONTINUOUS: assert property (ce && state_q == SPP_ST_WRAP && continuous
        && mode_q != SPP_MODE_OFF |=> remain_q == CNT_MAX && state_q == SPP_ST_LOAD)
        else $error("Continuous profile terminated or tally moved.");
    AST_TALLY_LOCK: assert property (active |=> $stable(prog_cnt_q) || !ce)
        else $error("Tally changed during execution.");
    AST_TALLY_RANGE: assert property (prog_cnt_q >= CNT_MIN && prog_cnt_q <= CNT_MAX)
        else $error("Programmed tally out of range.");
    AST_DUR_RANGE: assert property (state_q == SPP_ST_RAMP |-> dur_q != DUR_ZERO
        && dur_q <= DUR_MAX && elapsed_q < dur_q)
        else $error("Running segment has an illegal duration.");
    AST_ZERO_DUR: assert property (ce && state_q == SPP_ST_WAIT && rdur_b == DUR_ZERO
        && mode_q != SPP_MODE_OFF |=> state_q == SPP_ST_WRAP || state_q == SPP_ST_OFF)
        else $error("Zero duration did not end the cycle.");
    AST_HOLD: assert property (state_q == SPP_ST_RAMP && start_q == end_q
        |-> out_sp_q == start_q)
        else $error("Dwell segment output moved.");
    AST_INTERP_BOUND: assert property (state_q == SPP_ST_RAMP |-> (out_sp_q >= start_q
        && out_sp_q <= end_q) || (out_sp_q <= start_q && out_sp_q >= end_q))
        else $error("Interpolated setpoint outside segment ends.");
    AST_TALLY_DEC: assert property (ce && state_q == SPP_ST_WRAP && !continuous && !finish
        && mode_q != SPP_MODE_OFF |=> remain_q == $past(remain_q) - 1'b1)
        else $error("Tally did not drop by one at cycle end.");

endmodule : spp_seq
`default_nettype wire

// ==== spp_seq_test.sv ====
// Testbench for the setpoint profile sequencer.
`timescale 1ns/100ps
`default_nettype none
module spp_seq_test;
    import spp_pkg::*;
    // ========================================================================
    // Signals
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, act;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic signed [15:0] sp, lsp, lt;
    int fails = 0, n_compared = 0;
    spp_seq #(.TICK_CYCLES(36'h4)) i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .setpoint_out(sp),
        .local_setpoint(lsp), .profile_active(act));
    spp_loop_model i_loop (.pclk(pclk), .presetn(presetn), .setpoint_in(sp), .loop_target(lt));
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    // ========================================================================
    // Tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // One APB transfer; pready, read data and error are taken at the completing rising edge.
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
        int i;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
        if (i >= 50) begin fails++; tally_and_finish(); end
        if (!w) chk(prdata, ed);
        chk({31'h0, pslverr}, {31'h0, ee});
        psel <= 0; penable <= 0;
    endtask : acc
    // Bounded wait until the setpoint moves or the profile goes idle.
    task automatic wt(input logic idle, input logic signed [15:0] old);
        int i;
        i = 0;
        do begin @(negedge pclk); i++; end
        while ((idle ? act !== 1'b0 : sp === old) && i < 2000);
        if (i >= 2000) begin fails++; tally_and_finish(); end
    endtask : wt
    // ========================================================================
    // Scenarios
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1;
        acc(0, OFF_COUNT, 0, 32'h1, 0);
        acc(0, OFF_DUR_BASE, 0, 32'h0, 0);
        acc(0, OFF_TGT_BASE, 0, 32'h1388, 0);
        acc(1, OFF_COUNT, 32'h0, 0, 1);
        acc(1, OFF_COUNT, 32'hfb, 0, 1);
        acc(1, OFF_DUR_BASE, 32'd10000, 0, 1);
        acc(0, 12'hffc, 0, 32'h0, 1);
        acc(1, OFF_TGT_BASE, 32'd100, 0, 0);
        acc(1, OFF_DUR_BASE, 32'd2, 0, 0);
        acc(1, OFF_TGT_BASE + 12'h4, 32'd100, 0, 0);
        acc(1, OFF_DUR_BASE + 12'h4, 32'd1, 0, 0);
        acc(1, OFF_COUNT, 32'd2, 0, 0);
        acc(1, OFF_CTRL, 32'h1, 0, 0);
        acc(1, OFF_COUNT, 32'd5, 0, 1);
        acc(0, OFF_COUNT, 0, 32'd2, 0);
        wt(0, 0);
        chk({16'h0, sp}, 32'd50);
        wt(1, 0);
        chk({16'h0, lsp}, 32'd100);
        acc(1, OFF_TGT_BASE, 32'd200, 0, 0);
        acc(1, OFF_DUR_BASE, 32'd4, 0, 0);
        acc(1, OFF_DUR_BASE + 12'h4, 32'd0, 0, 0);
        acc(1, OFF_COUNT, 32'd1, 0, 0);
        acc(1, OFF_CTRL, 32'h1, 0, 0);
        wt(0, 100);
        chk({16'h0, sp}, 32'd125);
        acc(1, OFF_CTRL, 32'h2, 0, 0);
        acc(0, OFF_SETP, 0, 32'd150, 0);
        repeat (40) @(posedge pclk);
        chk({16'h0, sp}, 32'd150);
        chk({16'h0, lt}, 32'd150);
        acc(1, OFF_CTRL, 32'h1, 0, 0);
        wt(1, 0);
        chk({16'h0, lsp}, 32'd200);
        acc(1, OFF_COUNT, 32'd250, 0, 0);
        acc(1, OFF_CTRL, 32'h1, 0, 0);
        repeat (300) @(posedge pclk);
        chk({31'h0, act}, 32'h1);
        chk({16'h0, sp}, 32'd200);
        acc(0, OFF_COUNT, 0, 32'd250, 0);
        acc(1, OFF_CTRL, 32'h0, 0, 0);
        wt(1, 0);
        chk({16'h0, lsp}, 32'd200);
        tally_and_finish();
    end
endmodule : spp_seq_test
`default_nettype wire
